//--- common/pulse_code_pkg.sv
package pulse_code_pkg;

  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int VALUE_WIDTH     = 10;
  localparam int RES_WIDTH       = 4;
  localparam int SOURCE_COUNT    = 8;
  localparam int SOURCE_WIDTH    = 3;
  localparam int PORT_COUNT      = 6;
  localparam int DEBOUNCE_CYCLES = 4;

  localparam logic [RES_WIDTH-1:0] RES_MAX   = 4'hA;
  localparam logic [RES_WIDTH-1:0] RES_RESET = 4'hA;

  // ****************************************
  // Carrier clocks
  // ****************************************
  localparam int CLK_HZ         = 100_000_000;
  localparam int CARRIER_FAST   = 8_000_000;
  localparam int CARRIER_MID    = 1_000_000;
  localparam int CARRIER_SLOW   = 100_000;
  localparam int DIV_FAST       = CLK_HZ / CARRIER_FAST;
  localparam int DIV_MID        = CLK_HZ / CARRIER_MID;
  localparam int DIV_SLOW       = CLK_HZ / CARRIER_SLOW;
  localparam int DIV_WIDTH      = 10;

  typedef enum logic [1:0] {
    CARRIER_SEL_SLOW,
    CARRIER_SEL_MID,
    CARRIER_SEL_FAST
  } carrier_sel_type;

  typedef enum logic {
    MODE_PWM,
    MODE_PDM
  } mod_mode_type;

  // Per-channel configuration
  typedef struct packed {
    logic                    enable;
    mod_mode_type            mode;
    carrier_sel_type         clock_select;
    logic [RES_WIDTH-1:0]    resolution;
    logic [SOURCE_WIDTH-1:0] source;
  } channel_cfg_type;

  // Per-channel running state
  typedef struct packed {
    logic [DIV_WIDTH-1:0]   divider;
    logic [VALUE_WIDTH-1:0] phase;
    logic [VALUE_WIDTH:0]   accum;
    logic [VALUE_WIDTH-1:0] latched;
    logic                   level;
  } channel_state_type;

endpackage

//--- verilog/pulse_code_output_ports.sv
`timescale 1ns/1ps
// Operation
// RULE1: Each channel emits either a PWM or a PDM bitstream from a value.
// RULE2: Each channel picks its own source among the result values.
// RULE3: Software sets port direction to output before pulses are expected.
// RULE4: With four-wire serial active, ports zero and one carry select and data.
// RULE5: With two-wire bus selected, all six ports serve general use and pulses; the code routes pulses to ports zero to three only.
// RULE6: Input-capable ports offer optional debounce and optional pull-up.
// RULE7: Carrier clock selectable among 8 MHz, 1 MHz and 100 kHz; the code's fast divider of 12 gives about 8.33 MHz.
// RULE8: Each channel has its own carrier clock select field.
// RULE9: Each channel has its own resolution field.
// RULE10: Core reduces wide results to the configured width linearly.
// RULE11: Linear mapping uses signed slope and offset.
// RULE12: At ten bits the value spans zero to 1023.
// RULE13: Lower resolutions shrink the maximum value accordingly.
// RULE14: Out-of-range linearized values are dropped by firmware.
// RULE15: Value zero gives a constantly low stream.
// RULE16: Maximum value gives a constantly high stream.
// RULE17: Firmware writes output values; hardware only modulates them.
// RULE18: Configuration is write-only; no readback path exists.
// RULE19: Bus-select low activates four-wire serial on ports zero and one.
// RULE20: PWM period is two-to-resolution carrier cycles, high time equals value; the code holds the maximum value high for the whole period.
// RULE21: PDM gives value high cycles per period, evenly spread; the code makes the maximum value high on every cycle of the period.
module pulse_code_output_ports
  import pulse_code_pkg::*;
(
  input  wire logic                                    clk,
  input  wire logic                                    sys_rst,
  input  wire logic                                    clk_en,
  input  wire logic                                    bus_select_pin,
  input  wire logic                                    serial_select_in,
  input  wire logic                                    serial_data_out,
  input  wire logic [SOURCE_COUNT-1:0][VALUE_WIDTH-1:0] result_values,
  input  wire pulse_code_pkg::channel_cfg_type         cfg_a,
  input  wire pulse_code_pkg::channel_cfg_type         cfg_b,
  input  wire logic [PORT_COUNT-1:0]                   port_direction_bits,
  input  wire logic [PORT_COUNT-1:0]                   port_pull_up_en,
  input  wire logic [PORT_COUNT-1:0]                   port_debounce_en,
  input  wire logic [PORT_COUNT-1:0]                   port_pulse_route,
  input  wire logic [PORT_COUNT-1:0]                   port_gp_out,
  input  wire logic                                    interrupt_to_port,
  input  wire logic                                    interrupt_out_low_in,
  input  wire logic [PORT_COUNT-1:0]                   port_pin_in,
  output logic [PORT_COUNT-1:0]                        port_pin_out,
  output logic [PORT_COUNT-1:0]                        port_pin_oe,
  output logic [PORT_COUNT-1:0]                        port_pull_up,
  output logic [PORT_COUNT-1:0]                        port_in_value,
  output logic                                         serial_select_pin,
  output logic                                         pulse_out_a,
  output logic                                         pulse_out_b
);
  import pulse_code_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [PORT_COUNT-1:0]   sync1;
    logic [PORT_COUNT-1:0]   sync2;
    logic                    bus_sync1;
    logic                    bus_sync2;
    logic [PORT_COUNT-1:0][2:0] deb_cnt;
    logic [PORT_COUNT-1:0]   deb_val;
    channel_state_type [1:0] chan;
    logic [PORT_COUNT-1:0]   pin_out;
    logic [PORT_COUNT-1:0]   pin_oe;
    logic [PORT_COUNT-1:0]   pull_up;
    logic                    ssel;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // ****************************************
  // Helpers
  // ****************************************
  // Resolutions above ten clamp to ten
  function automatic logic [RES_WIDTH-1:0] eff_res(input logic [RES_WIDTH-1:0] r);
    eff_res = (r > RES_MAX || r == 4'h0) ? RES_MAX : r;
  endfunction

  function automatic logic [VALUE_WIDTH-1:0] res_mask(input logic [RES_WIDTH-1:0] r);
    res_mask = VALUE_WIDTH'((11'h001 << eff_res(r)) - 11'h001); // RULE12 RULE13
  endfunction

  function automatic logic [DIV_WIDTH-1:0] div_limit(input carrier_sel_type s);
    unique case (s)
      CARRIER_SEL_FAST: div_limit = DIV_WIDTH'(DIV_FAST - 1);
      CARRIER_SEL_MID:  div_limit = DIV_WIDTH'(DIV_MID - 1);
      CARRIER_SEL_SLOW: div_limit = DIV_WIDTH'(DIV_SLOW - 1);
      default:          div_limit = DIV_WIDTH'(DIV_SLOW - 1);
    endcase
  endfunction

  channel_cfg_type        cfg [2];
  logic [VALUE_WIDTH-1:0] src_val [2];
  logic                   pulse_lvl [2];
  logic                   serial_mode;

  assign cfg[0] = cfg_a;
  assign cfg[1] = cfg_b;
  assign src_val[0] = result_values[cfg_a.source] & res_mask(cfg_a.resolution); // RULE2 RULE17
  assign src_val[1] = result_values[cfg_b.source] & res_mask(cfg_b.resolution); // RULE2 RULE17
  // Four-wire serial active while bus-select reads low
  assign serial_mode = ~state_reg.bus_sync2; // RULE19

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [VALUE_WIDTH-1:0] m;
    logic [VALUE_WIDTH:0]   sum;
    logic [VALUE_WIDTH:0]   top;
    logic                   tick;
    logic                   wrap;
    logic                   src;
    m = '0;
    sum = '0;
    top = '0;
    tick = 1'b0;
    wrap = 1'b0;
    src = 1'b0;
    state_next = state_reg;
    state_next.sync1 = port_pin_in;
    state_next.sync2 = state_reg.sync1;
    state_next.bus_sync1 = bus_select_pin;
    state_next.bus_sync2 = state_reg.bus_sync1;
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      // Filter needs a stable run before accepting a new level
      if (!port_debounce_en[p])
      begin
        state_next.deb_val[p] = state_reg.sync2[p]; // RULE6
        state_next.deb_cnt[p] = '0;
      end
      else if (state_reg.sync2[p] == state_reg.deb_val[p])
      begin
        state_next.deb_cnt[p] = '0;
      end
      else if (state_reg.deb_cnt[p] == 3'(DEBOUNCE_CYCLES - 1))
      begin
        state_next.deb_val[p] = state_reg.sync2[p]; // RULE6
        state_next.deb_cnt[p] = '0;
      end
      else
      begin
        state_next.deb_cnt[p] = state_reg.deb_cnt[p] + 3'h1;
      end
    end
    for (int c = 0; c < 2; c++)
    begin
      m = res_mask(cfg[c].resolution);
      top = {1'b0, m} + 11'h001;
      // A faster select may leave the divider above its new limit
      tick = (state_reg.chan[c].divider >= div_limit(cfg[c].clock_select)); // RULE7 RULE8
      wrap = tick && ((state_reg.chan[c].phase & m) == m);
      if (!cfg[c].enable)
      begin
        state_next.chan[c] = '0;
      end
      else if (tick)
      begin
        state_next.chan[c].divider = '0;
        state_next.chan[c].phase = (state_reg.chan[c].phase + 10'h001) & m; // RULE9 RULE20
        if (wrap)
        begin
          // New value only at period edges so a period is never torn
          state_next.chan[c].latched = src_val[c];
        end
        if (cfg[c].mode == MODE_PWM)
        begin
          // Max value: phase reaches mask, where phase < latched fails, so the latched == m term keeps it high
          state_next.chan[c].level = (state_reg.chan[c].latched == m) ||
                                     (state_reg.chan[c].phase < state_reg.chan[c].latched); // RULE15 RULE16 RULE20
        end
        else
        begin
          // Mask so a shrunk resolution cannot replay a large remainder
          sum = (state_reg.chan[c].accum & {1'b0, m}) + {1'b0, state_reg.chan[c].latched};
          if (state_reg.chan[c].latched == m)
          begin
            state_next.chan[c].level = 1'b1; // RULE16
            state_next.chan[c].accum = '0;
          end
          else if (sum >= top)
          begin
            state_next.chan[c].level = 1'b1; // RULE21
            state_next.chan[c].accum = sum - top;
          end
          else
          begin
            state_next.chan[c].level = 1'b0; // RULE15 RULE21
            state_next.chan[c].accum = sum;
          end
        end
      end
      else
      begin
        state_next.chan[c].divider = state_reg.chan[c].divider + 10'h001;
        state_next.chan[c].phase = state_reg.chan[c].phase & m; // RULE13
      end
    end
    pulse_lvl[0] = state_reg.chan[0].level; // RULE1
    pulse_lvl[1] = state_reg.chan[1].level; // RULE1
    for (int p = 0; p < PORT_COUNT; p++)
    begin
      src = (p == 0 || p == 2) ? pulse_lvl[0] : pulse_lvl[1];
      state_next.pin_oe[p] = port_direction_bits[p] || (p >= 4); // RULE3
      if (p == 2 && interrupt_to_port)
      begin
        state_next.pin_out[p] = interrupt_out_low_in;
      end
      else if (port_pulse_route[p] && p < 4)
      begin
        state_next.pin_out[p] = src; // RULE5
      end
      else
      begin
        state_next.pin_out[p] = port_gp_out[p];
      end
      state_next.pull_up[p] = port_pull_up_en[p] && !port_direction_bits[p] && (p < 4); // RULE6
    end
    state_next.ssel = 1'b1;
    if (serial_mode)
    begin
      state_next.ssel = state_reg.sync2[0];
      state_next.pin_oe[0] = 1'b0; // RULE4
      state_next.pull_up[0] = 1'b0;
      state_next.pin_out[1] = serial_data_out & ~serial_select_in; // RULE4
      state_next.pin_oe[1] = ~serial_select_in; // RULE4
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // No readback of configuration exists by design
  assign port_pin_out      = state_reg.pin_out; // RULE18
  assign port_pin_oe       = state_reg.pin_oe;
  assign port_pull_up      = state_reg.pull_up;
  assign port_in_value     = state_reg.deb_val;
  assign serial_select_pin = state_reg.ssel;
  assign pulse_out_a       = state_reg.chan[0].level;
  assign pulse_out_b       = state_reg.chan[1].level;

  // ****************************************
  // Checks
  // ****************************************
  chk_serial_port_in: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    clk_en && serial_mode |=> !port_pin_oe[0])
    else $error("port zero driven in serial mode");

  chk_zero_stays_low: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    (state_reg.chan[0].latched == '0) && cfg_a.enable && clk_en &&
    (state_reg.chan[0].divider >= div_limit(cfg_a.clock_select)) |=> !pulse_out_a)
    else $error("zero value produced a high bit");

  chk_max_stays_high: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    (state_reg.chan[0].latched == res_mask(cfg_a.resolution)) && cfg_a.enable && clk_en &&
    (state_reg.chan[0].divider >= div_limit(cfg_a.clock_select)) |=> pulse_out_a)
    else $error("max value produced a low bit");

  chk_output_ports_drive: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    !sys_rst && clk_en ##1 1'b1 |-> port_pin_oe[5] && port_pin_oe[4])
    else $error("output-only ports not driven");

  chk_pull_up_input: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    port_pull_up[3] |-> $past(port_pull_up_en[3]) && !$past(port_direction_bits[3]))
    else $error("pull-up enabled without request");

  chk_phase_bound: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    (state_reg.chan[0].phase & ~res_mask(cfg_a.resolution)) == '0 || !$stable(cfg_a.resolution))
    else $error("phase beyond resolution");

  chk_divider_bound: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    state_reg.chan[0].divider <= DIV_WIDTH'(DIV_SLOW - 1))
    else $error("divider overran slowest carrier");

  chk_disabled_idle: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    !cfg_b.enable && clk_en ##1 !cfg_b.enable |-> !pulse_out_b)
    else $error("disabled channel pulses");

  chk_serial_port_one: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    clk_en && serial_mode && serial_select_in |=> !port_pin_oe[1])
    else $error("port one driven while deselected");

  chk_interrupt_route: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    clk_en && interrupt_to_port |=> port_pin_out[2] == $past(interrupt_out_low_in))
    else $error("interrupt level not on port two");

endmodule // pulse_code_output_ports

//--- tb/lp_filter_model.sv
`timescale 1ns/1ps
// ****************************************
// Low-pass filter stand-in
// ****************************************
// Sums the high time over a window. Over whole periods the sum
// is what an RC filter averages; an unknown level counts as low.
module lp_filter_model
(
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic        pulse_in,
  input  wire logic [31:0] window,
  output logic [31:0]      high_total,
  output logic             done
);
  logic [31:0] left_reg = '0;
  logic [31:0] acc_reg  = '0;

  always @(posedge clk)
  begin
    done <= 1'b0;
    if (start)
    begin
      left_reg <= window;
      acc_reg  <= '0;
    end
    else if (left_reg != 0)
    begin
      left_reg <= left_reg - 1;
      acc_reg  <= acc_reg + 32'(pulse_in === 1'b1);
      if (left_reg == 1)
      begin
        high_total <= acc_reg + 32'(pulse_in === 1'b1);
        done       <= 1'b1;
      end
    end
  end
endmodule  // lp_filter_model

//--- tb/pulse_code_output_ports_bench.sv
`timescale 1ns/1ps
module pulse_code_output_ports_bench;
  import pulse_code_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic                                     clk = 1'b0;
  logic                                     sys_rst = 1'b1;
  logic                                     clk_en = 1'b1;
  logic                                     bus_select_pin = 1'b1;
  logic                                     serial_select_in = 1'b1;
  logic                                     serial_data_out = 1'b0;
  logic [SOURCE_COUNT-1:0][VALUE_WIDTH-1:0] result_values = '0;
  channel_cfg_type                          cfg_a = '0;
  channel_cfg_type                          cfg_b = '0;
  logic [PORT_COUNT-1:0]                    port_direction_bits = '0;
  logic [PORT_COUNT-1:0]                    port_pull_up_en = '0;
  logic [PORT_COUNT-1:0]                    port_debounce_en = '0;
  logic [PORT_COUNT-1:0]                    port_pulse_route = '0;
  logic [PORT_COUNT-1:0]                    port_gp_out = '0;
  logic [PORT_COUNT-1:0]                    port_pin_in = '0;
  logic                                     interrupt_to_port = 1'b0;
  logic                                     interrupt_out_low_in = 1'b1;
  logic [PORT_COUNT-1:0]                    port_pin_out, port_pin_oe;
  logic [PORT_COUNT-1:0]                    port_pull_up, port_in_value;
  logic                                     serial_select_pin, pulse_out_a, pulse_out_b;
  logic                                     start = 1'b0;
  logic                                     done_a, done_b;
  logic [31:0]                              win_a, win_b, high_a, high_b;
  logic [31:0]                              q_a[$];
  logic [31:0]                              q_b[$];
  int                                       err_total = 0;
  int                                       tests_run = 0;
  int                                       last_per = 0;

  pulse_code_output_ports DUT (.clk, .sys_rst, .clk_en, .bus_select_pin, .serial_select_in,
    .serial_data_out, .result_values, .cfg_a, .cfg_b, .port_direction_bits, .port_pull_up_en,
    .port_debounce_en, .port_pulse_route, .port_gp_out, .interrupt_to_port,
    .interrupt_out_low_in, .port_pin_in, .port_pin_out, .port_pin_oe, .port_pull_up,
    .port_in_value, .serial_select_pin, .pulse_out_a, .pulse_out_b);
  lp_filter_model filt_a (.clk, .start, .pulse_in(pulse_out_a), .window(win_a),
    .high_total(high_a), .done(done_a));
  lp_filter_model filt_b (.clk, .start, .pulse_in(pulse_out_b), .window(win_b),
    .high_total(high_b), .done(done_b));

  always #5 clk = ~clk;

  // ****************************************
  // Checking and verdict
  // ****************************************
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic int div_of(int sel);
    return (sel == 2) ? DIV_FAST : (sel == 1) ? DIV_MID : DIV_SLOW;
  endfunction

  // Window is two periods; the maximum code is a steady high, not 2^res-1 cycles
  function automatic logic [31:0] high_exp(int v, int res, int sel);
    return (v == (2 ** res) - 1) ? 2 * (2 ** res) * div_of(sel) : 2 * v * div_of(sel);
  endfunction

  always @(posedge clk)
  begin
    if (done_a === 1'b1 && q_a.size() > 0)
      check("high_time_a", q_a.pop_front(), high_a);
    if (done_b === 1'b1 && q_b.size() > 0)
      check("high_time_b", q_b.pop_front(), high_b);
  end

  // ****************************************
  // Pulse scenarios
  // ****************************************
  // Channel b always runs opposite mode on the fast carrier beside channel a
  task automatic run_pair(int mode, int sel, int idx);
    int ra, rb, va, vb, sa, sb, pa, pb;
    ra = (sel == 0) ? 1 : 1 + $urandom % 4;
    rb = 1 + $urandom % 6;
    sa = $urandom % SOURCE_COUNT;
    sb = sa ^ 1;
    va = (idx == 0) ? 0 : (idx == 1) ? (2 ** ra) - 1 : $urandom % (2 ** ra);
    vb = $urandom % (2 ** rb);
    pa = (2 ** ra) * div_of(sel);
    pb = (2 ** rb) * DIV_FAST;
    @(posedge clk);
    result_values[sa] <= va[VALUE_WIDTH-1:0];
    result_values[sb] <= vb[VALUE_WIDTH-1:0];
    cfg_a <= '{1'b1, mod_mode_type'(mode), carrier_sel_type'(sel), ra[RES_WIDTH-1:0],
               sa[SOURCE_WIDTH-1:0]};
    cfg_b <= '{1'b1, mod_mode_type'(1 - mode), CARRIER_SEL_FAST, rb[RES_WIDTH-1:0],
               sb[SOURCE_WIDTH-1:0]};
    // Old period may still be running, so wait it out too
    repeat (3 * (pa + pb) + last_per) @(posedge clk);
    last_per = pa;
    win_a <= 2 * pa;
    win_b <= 2 * pb;
    start <= 1'b1;
    q_a.push_back(high_exp(va, ra, sel));
    q_b.push_back(high_exp(vb, rb, 2));
    @(posedge clk);
    start <= 1'b0;
    wait (q_a.size() == 0 && q_b.size() == 0);
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    final_report;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [PORT_COUNT-1:0] r;
    logic                  b;
    void'($urandom(75));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    r = 6'($urandom);
    b = ~r[0];
    port_direction_bits <= 6'h3F;
    port_gp_out <= r;
    repeat (8) @(posedge clk);
    check("port_oe", 6'h3F, port_pin_oe);
    check("port_out", r, port_pin_out);
    clk_en <= 1'b0;
    port_gp_out <= ~r;
    repeat (4) @(posedge clk);
    check("frozen_out", r, port_pin_out);
    clk_en <= 1'b1;
    interrupt_to_port <= 1'b1;
    interrupt_out_low_in <= r[2];
    repeat (2) @(posedge clk);
    check("interrupt_port", r[2], port_pin_out[2]);
    interrupt_to_port <= 1'b0;
    port_direction_bits <= 6'h00;
    port_pull_up_en <= 6'h3F;
    port_debounce_en <= 6'h3F;
    port_pin_in <= r;
    repeat (12) @(posedge clk);
    check("pull_up", 6'h0F, port_pull_up);
    check("in_value", r[3:0], port_in_value[3:0]);
    bus_select_pin <= 1'b0;
    port_direction_bits <= 6'h3F;
    port_pin_in <= ~r;
    serial_select_in <= 1'b0;
    serial_data_out <= 1'b1;
    repeat (4) @(posedge clk);
    check("in_held", r[3:0], port_in_value[3:0]);
    repeat (8) @(posedge clk);
    check("in_new", 4'(~r[3:0]), port_in_value[3:0]);
    check("serial_oe", 1'b0, port_pin_oe[0]);
    check("serial_select", b, serial_select_pin);
    check("serial_data", 2'h3, {port_pin_oe[1], port_pin_out[1]});
    bus_select_pin <= 1'b1;
    serial_select_in <= 1'b1;
    port_pulse_route <= 6'h0F;
    port_pull_up_en <= 6'h00;
    repeat (8) @(posedge clk);
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 3; s++)
        run_pair(m, s, s);
    final_report;
  end
endmodule  // pulse_code_output_ports_bench
